// ---- design/saceng_top.sv ----
// command interpreter of the sensor acquisition engine, apb slave
// Summary of operation
// - first number is command, rest parameters
// - omitted trailing parameters take defaults
// - command 0 clears all setup
// - command 1 sets up a channel
// - channels 1-4 analog, 11/12 motion
// - operation 1 marks self-calibrated probe
// - command 3 starts timed acquisition
// - interval 0.0001 to 16000 seconds
// - count up to 12287, then stop
// - count -1 samples continuously
// - trigger 0 now, 1 button, else level
// - stored readings returned as one block
// - values first, then sample times
// - live mode gives one reading per interval
// - command 9 takes one reading
// - conversion 1 applies command 4 calibration when the equation is linear (1), except on an operation 1 probe
// - command 4 sets equation and coefficients of analog channels 1-4, motion channels refused
// - linear result is intercept plus slope*volts
`timescale 1ns/100ps
module saceng_top
	import saceng_pkg::*;
#(
	parameter int DEPTH     = 12287,
	parameter int TICK_CYCLES = TICK_CYC
)(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// sensor readings, same clock domain
	input  saceng_sense_t    sense,
	// front panel start button, asynchronous
	input  wire logic        start_btn,
	// acquisition armed or running
	output logic             acq_busy
);
	// ********************************************
	// state
	// ********************************************
	typedef struct packed {
		logic [LIST_LEN-1:0][31:0] list;
		logic [3:0]                list_n;
		saceng_state_t             st;
		saceng_chan_t [5:0]        chan;
		logic [2:0]                acq_slot;
		logic [2:0]                trig_slot;
		logic [1:0]                trig;
		logic [31:0]               trig_thr;
		logic                      live;
		logic [13:0]               count;
		logic [13:0]               n_done;
		logic [31:0]               ivl_ticks;
		logic [31:0]               ivl_cnt;
		logic [31:0]               tick_cnt;
		logic [31:0]               now;
		logic [31:0]               live_word;
		logic                      fresh;
		logic                      err_chan;
		logic                      err_param;
		logic [14:0]               rd_ptr;
		logic                      pop_live;
		logic                      pop_mem;
		logic                      btn_q1;
		logic                      btn_q2;
		logic                      btn_prev;
		logic                      pready;
		logic                      pslverr;
		logic [31:0]               prdata;
	} saceng_regs_t;

	localparam saceng_regs_t RST = '0;

	saceng_regs_t           r;
	saceng_regs_t           nx;
	logic [31:0]            mem_val [DEPTH];
	logic [31:0]            mem_time [DEPTH];
	logic [31:0]            mem_q;
	logic [LIST_LEN-1:0][31:0] par;
	logic [15:0]            code;
	logic [5:0][31:0]       raw;
	logic [2:0]             sel;
	logic [31:0]            cal_out;
	logic [3:0]             sl1;
	logic [3:0]             sl4;
	logic                   acc;
	logic                   fin;
	logic                   mapped;
	logic                   tick;
	logic                   btn_rise;
	logic                   samp_take;
	logic                   exec_now;
	logic                   stream_ok;
	logic                   wr_en;
	logic [31:0]            wr_time;
	logic [47:0]            ivl_prod;
	logic [31:0]            ivl_t;
	logic [15:0]            cnt_i;
	logic [15:0]            trg_i;
	logic                   acq_ok;
	logic [31:0]            status_word;

	// ********************************************
	// helpers
	// ********************************************
	// integer part of a fixed point number
	function automatic logic [15:0] int_of(input logic [31:0] q);
		int_of = q[31:16];
	endfunction : int_of

	// channel code to slot: {valid, index}
	function automatic logic [3:0] slot_of(input logic [15:0] c);
		slot_of = 4'h0;
		// analog 1-4, motion ports 11 and 12
		if (c >= 16'h0001 && c <= CH_ANALOG_LAST) begin
			slot_of = {1'b1, 3'(c - 16'h0001)};
		end else if (c == CH_MOTION1) begin
			slot_of = 4'hC;
		end else if (c == CH_MOTION2) begin
			slot_of = 4'hD;
		end
	endfunction : slot_of

	// default for an omitted parameter
	function automatic logic [31:0] def_par(input logic [15:0] c, input int i);
		def_par = 32'h0;
		if (c == CMD_SETUP && i == 1) def_par = DEF_CHANNEL;
		if (c == CMD_SETUP && i == 2) def_par = DEF_OP;
		if (c == CMD_SAMPLE && i == 1) def_par = DEF_INTERVAL;
		if (c == CMD_SAMPLE && i == 2) def_par = DEF_COUNT;
		if (c == CMD_SAMPLE && i == 3) def_par = DEF_TRIG;
		if (c == CMD_SAMPLE && i == 4) def_par = DEF_CHANNEL;
		if (c == CMD_CALIB && i == 1) def_par = DEF_CHANNEL;
		if (c == CMD_CALIB && i == 2) def_par = DEF_EQ;
		if (c == CMD_CALIB && i == 4) def_par = DEF_SLOPE;
	endfunction : def_par

	// ********************************************
	// command list decode
	// ********************************************
	// code is the first number of the list
	assign code = int_of(r.list[0]);

	genvar gi;
	generate
		for (gi = 0; gi < LIST_LEN; gi++) begin : g_par
			assign par[gi] = (4'(gi) < r.list_n) ? r.list[gi] : def_par(code, gi);
		end
	endgenerate

	assign raw = {sense.motion, sense.analog};
	assign sl1 = slot_of(int_of(par[1]));
	assign sl4 = slot_of(int_of(par[4]));
	assign sel = (code == CMD_SINGLE) ? sl1[2:0] : r.acq_slot;

	assign ivl_prod = 48'(par[1]) * 48'(TICKS_PER_S);
	assign ivl_t    = ivl_prod[47:16];
	assign cnt_i    = int_of(par[2]);
	assign trg_i    = int_of(par[3]);

	// ********************************************
	// conversion of the selected channel
	// ********************************************
	saceng_calib u_calib (
		.raw   (raw[sel]),
		.chan  (r.chan[sel]),
		.value (cal_out)
	);

	// ********************************************
	// stored readings
	// ********************************************
	// readings kept until the host fetches them
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem_val[r.n_done]  <= cal_out;
			mem_time[r.n_done] <= wr_time;
		end
	end

	always_ff @(posedge mclk) begin
		if (r.rd_ptr < 15'(r.count)) begin
			mem_q <= mem_val[r.rd_ptr[13:0]];
		end else begin
			mem_q <= mem_time[14'(r.rd_ptr - 15'(r.count))];
		end
	end

	assign stream_ok = (r.st == ST_DONE) && !r.live && (r.rd_ptr < {r.count, 1'b0});
	assign mapped = (paddr == OFS_PARAM) || (paddr == OFS_EXEC) || (paddr == OFS_STATUS)
		|| (paddr == OFS_DATA);
	assign status_word = {2'h0, r.n_done, 10'h0, r.err_param, r.err_chan, r.fresh, r.live,
		r.st};
	// sample interval, count and trigger channel all legal
	assign acq_ok = ($signed(par[1]) > 0) && (par[1] <= IVL_MAX_Q) && (ivl_t != 32'h0)
		&& ((cnt_i == COUNT_LIVE) || ($signed(cnt_i) > 0 && cnt_i <= COUNT_MAX))
		&& (trg_i == TRIG_NOW || trg_i == TRIG_BUTTON || sl4[3]);

	// ********************************************
	// next state
	// ********************************************
	always_comb begin
		nx = r;
		wr_en = 1'b0;
		samp_take = 1'b0;
		wr_time = r.now + 32'h1;
		// button synchroniser and edge
		nx.btn_q1 = start_btn;
		nx.btn_q2 = r.btn_q1;
		nx.btn_prev = r.btn_q2;
		btn_rise = r.btn_q2 & ~r.btn_prev;
		// time base divider
		tick = (r.tick_cnt == 32'(TICK_CYCLES - 1));
		nx.tick_cnt = tick ? 32'h0 : r.tick_cnt + 32'h1;
		// apb: answer one cycle into the access phase
		acc = psel & penable & ~r.pready;
		fin = psel & penable & r.pready;
		exec_now = fin & pwrite & (paddr == OFS_EXEC);
		nx.pready = acc;
		nx.pslverr = acc & ~mapped;
		nx.prdata = 32'h0;
		nx.pop_live = 1'b0;
		nx.pop_mem = 1'b0;
		if (acc && !pwrite && paddr == OFS_STATUS) begin
			nx.prdata = status_word;
		end else if (acc && !pwrite && paddr == OFS_DATA) begin
			nx.prdata = r.fresh ? r.live_word : (stream_ok ? mem_q : 32'h0);
			nx.pop_live = r.fresh;
			nx.pop_mem = ~r.fresh & stream_ok;
		end
		// read of the data word consumes it
		if (fin && r.pop_live) begin
			nx.fresh = 1'b0;
		end
		if (fin && r.pop_mem) begin
			nx.rd_ptr = r.rd_ptr + 15'h1;
		end
		// numbers append to the command list
		if (fin && pwrite && paddr == OFS_PARAM) begin
			if (r.list_n < 4'(LIST_LEN)) begin
				nx.list[r.list_n] = pwdata;
				nx.list_n = r.list_n + 4'h1;
			end else begin
				nx.err_param = 1'b1;
			end
		end
		// acquisition sequencer
		case (r.st)
			ST_ARM: begin
				if ((r.trig == 2'h1 && btn_rise)
					|| (r.trig == 2'h2 && $signed(raw[r.trig_slot]) > $signed(r.trig_thr))) begin
					nx.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (tick) begin
					nx.now = r.now + 32'h1;
					nx.ivl_cnt = r.ivl_cnt + 32'h1;
					if (r.ivl_cnt == r.ivl_ticks - 32'h1) begin
						nx.ivl_cnt = 32'h0;
						samp_take = 1'b1;
					end
				end
			end
			default: begin
			end
		endcase
		if (samp_take && r.live) begin
			// one reading per interval, new reading wins over a read clear
			nx.live_word = cal_out;
			nx.fresh = 1'b1;
			nx.pop_live = 1'b0;
		end else if (samp_take) begin
			wr_en = 1'b1;
			nx.n_done = r.n_done + 14'h1;
			if (r.n_done + 14'h1 == r.count) begin
				nx.st = ST_DONE;
			end
		end
		// command execution
		if (exec_now) begin
			nx.list_n = 4'h0;
			if (r.list_n == 4'h0) begin
				nx.err_param = 1'b1;
			end else if (code == CMD_RESET) begin
				nx = RST;
				nx.btn_q1 = start_btn;
				nx.btn_q2 = r.btn_q1;
				nx.btn_prev = r.btn_q2;
			end else if (code == CMD_SETUP) begin
				if (sl1[3]) begin
					nx.chan[sl1[2:0]].used = 1'b1;
					nx.chan[sl1[2:0]].auto_id = (int_of(par[2]) == OP_AUTO);
					nx.chan[sl1[2:0]].conv = (int_of(par[5]) == CONV_CUSTOM);
					nx.acq_slot = sl1[2:0];
				end else begin
					nx.err_chan = 1'b1;
				end
			end else if (code == CMD_CALIB) begin
				if (sl1[3] && !sl1[2]) begin
					nx.chan[sl1[2:0]].eq = 8'(int_of(par[2]));
					nx.chan[sl1[2:0]].icpt = par[3];
					nx.chan[sl1[2:0]].slope = par[4];
				end else begin
					nx.err_chan = 1'b1;
				end
			end else if (code == CMD_SAMPLE) begin
				if (!r.chan[r.acq_slot].used) begin
					nx.err_chan = 1'b1;
				end else if (!acq_ok) begin
					nx.err_param = 1'b1;
				end else begin
					nx.live = (cnt_i == COUNT_LIVE);
					nx.count = 14'(cnt_i);
					nx.ivl_ticks = ivl_t;
					nx.trig = (trg_i == TRIG_NOW) ? 2'h0 : ((trg_i == TRIG_BUTTON) ? 2'h1 : 2'h2);
					nx.trig_slot = sl4[2:0];
					nx.trig_thr = par[5];
					nx.st = (trg_i == TRIG_NOW) ? ST_RUN : ST_ARM;
					nx.n_done = 14'h0;
					nx.now = 32'h0;
					nx.ivl_cnt = 32'h0;
					nx.rd_ptr = 15'h0;
					nx.fresh = 1'b0;
					wr_en = 1'b0;
				end
			end else if (code == CMD_STOP) begin
				if (int_of(par[1]) == 16'h0) begin
					nx.st = ST_IDLE;
					wr_en = 1'b0;
					// live mode ends too, an unread live reading is dropped
					nx.live = 1'b0;
					nx.fresh = 1'b0;
				end
			end else if (code == CMD_SINGLE) begin
				// one reading of a configured channel
				if (sl1[3] && r.chan[sl1[2:0]].used) begin
					nx.live_word = cal_out;
					nx.fresh = 1'b1;
				end else begin
					nx.err_chan = 1'b1;
				end
			end else begin
				nx.err_param = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			r <= RST;
		end else begin
			r <= nx;
		end
	end

	// outputs straight from flip-flops
	assign prdata   = r.prdata;
	assign pready   = r.pready;
	assign pslverr  = r.pslverr;
	assign acq_busy = r.st[0];

	// ********************************************
	// assertions
	// ********************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence seq_start_ok;
		exec_now && r.list_n != 4'h0 && code == CMD_SAMPLE && acq_ok
			&& r.chan[r.acq_slot].used;
	endsequence

	stop_goes_idle_a: assert property (
		exec_now && r.list_n != 4'h0 && code == CMD_STOP && int_of(par[1]) == 16'h0
		|=> r.st == ST_IDLE && !acq_busy && !r.live && !r.fresh)
		else $error("stop command did not idle");
	reset_clears_a: assert property (
		exec_now && r.list_n != 4'h0 && code == CMD_RESET
		|=> r.chan == '0 && r.st == ST_IDLE && !r.err_chan)
		else $error("reset command left setup");
	count_bound_a: assert property (
		r.st == ST_RUN && !r.live |-> r.n_done < r.count)
		else $error("stored count overrun");
	done_at_count_a: assert property (
		samp_take && !r.live && !exec_now && r.n_done + 14'h1 == r.count
		|=> r.st == ST_DONE ##1 r.st == ST_DONE)
		else $error("acquisition did not end at count");
	live_delivers_a: assert property (
		samp_take && r.live && !exec_now |=> r.fresh && r.live_word == $past(cal_out))
		else $error("live reading not delivered");
	trig_now_a: assert property (
		seq_start_ok and (trg_i == TRIG_NOW) |=> r.st == ST_RUN)
		else $error("immediate trigger did not run");
	trig_button_a: assert property (
		seq_start_ok and (trg_i == TRIG_BUTTON) |=> r.st == ST_ARM ##1 r.st != ST_DONE)
		else $error("button trigger did not arm");
	single_refuse_a: assert property (
		exec_now && r.list_n != 4'h0 && code == CMD_SINGLE && !(sl1[3] && r.chan[sl1[2:0]].used)
		|=> r.err_chan && $stable(r.live_word))
		else $error("unconfigured single read not refused");
endmodule : saceng_top

// ---- design/saceng_pkg.sv ----
// shared constants and types of the sensor acquisition command engine
package saceng_pkg;
	// ********************************************
	// register offsets (byte addresses on apb)
	// ********************************************
	localparam logic [11:0] OFS_PARAM  = 12'h000;
	localparam logic [11:0] OFS_EXEC   = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_DATA   = 12'h00C;
	// status word fields
	localparam int ST_LIVE_BIT  = 2;
	localparam int ST_FRESH_BIT = 3;
	localparam int ST_ECH_BIT   = 4;
	localparam int ST_EPAR_BIT  = 5;
	localparam int ST_NDONE_LSB = 16;
	// ********************************************
	// command codes and parameter encodings
	// ********************************************
	localparam logic [15:0] CMD_RESET  = 16'h0000;
	localparam logic [15:0] CMD_SETUP  = 16'h0001;
	localparam logic [15:0] CMD_SAMPLE = 16'h0003;
	localparam logic [15:0] CMD_CALIB  = 16'h0004;
	localparam logic [15:0] CMD_STOP   = 16'h0006;
	localparam logic [15:0] CMD_SINGLE = 16'h0009;
	localparam logic [15:0] CH_ANALOG_LAST = 16'h0004;
	localparam logic [15:0] CH_MOTION1     = 16'h000B;
	localparam logic [15:0] CH_MOTION2     = 16'h000C;
	localparam logic [15:0] OP_AUTO        = 16'h0001;
	localparam logic [15:0] CONV_CUSTOM    = 16'h0001;
	localparam logic [7:0]  EQ_LINEAR      = 8'h01;
	localparam logic [15:0] TRIG_NOW       = 16'h0000;
	localparam logic [15:0] TRIG_BUTTON    = 16'h0001;
	localparam logic [15:0] COUNT_LIVE     = 16'hFFFF;
	localparam logic [15:0] COUNT_MAX      = 16'h2FFF;
	localparam int LIST_LEN = 10;
	// numbers are signed fixed point, 16 fraction bits
	localparam logic [31:0] Q_ONE        = 32'h0001_0000;
	localparam logic [31:0] IVL_MAX_Q    = 32'h3E80_0000;
	// parameter defaults for omitted list entries
	localparam logic [31:0] DEF_CHANNEL  = 32'h0001_0000;
	localparam logic [31:0] DEF_OP       = 32'h0001_0000;
	localparam logic [31:0] DEF_INTERVAL = 32'h0001_0000;
	localparam logic [31:0] DEF_COUNT    = 32'h0001_0000;
	localparam logic [31:0] DEF_TRIG     = 32'h0001_0000;
	localparam logic [31:0] DEF_EQ       = 32'h0001_0000;
	localparam logic [31:0] DEF_SLOPE    = 32'h0001_0000;
	// ********************************************
	// timing: one time base tick of 100 us
	// ********************************************
	localparam int CLK_NS      = 5;
	localparam int TICK_NS     = 100000;
	localparam int TICK_CYC    = TICK_NS / CLK_NS;
	localparam int TICKS_PER_S = 1000000000 / TICK_NS;
	// ********************************************
	// types
	// ********************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARM  = 2'b01,
		ST_RUN  = 2'b11,
		ST_DONE = 2'b10
	} saceng_state_t;
	typedef struct packed {
		logic        used;
		logic        auto_id;
		logic        conv;
		logic [7:0]  eq;
		logic [31:0] icpt;
		logic [31:0] slope;
	} saceng_chan_t;
	typedef struct packed {
		logic [3:0][31:0] analog;
		logic [1:0][31:0] motion;
	} saceng_sense_t;
endpackage : saceng_pkg

// ---- design/saceng_calib.sv ----
// linear conversion of one raw channel reading
`timescale 1ns/100ps
module saceng_calib
	import saceng_pkg::*;
(
	// raw reading and channel setup
	input  wire logic [31:0] raw,
	input  saceng_chan_t     chan,
	// converted reading
	output logic      [31:0] value
);
	logic signed [63:0] prod;

	// ********************************************
	// conversion
	// ********************************************
	// slope times volts, fraction bits realigned below
	always_comb begin
		prod = $signed({{32{chan.slope[31]}}, chan.slope}) * $signed({{32{raw[31]}}, raw});
		value = raw;
		if (chan.conv && !chan.auto_id && chan.eq == EQ_LINEAR) begin
			value = chan.icpt + prod[47:16];
		end
	end
endmodule : saceng_calib

// ---- testbench/saceng_host.sv ----
// host model: apb master that sends command lists to the engine
`timescale 1ns/100ps
module saceng_host
	import saceng_pkg::*;
(
	// clock
	input  wire logic        mclk,
	// apb master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// ************************************
	// bus cycles
	// ************************************
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'hFFF;
		pwdata = 32'h0;
	end
	// one transfer, held until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines flip so a stale value never passes
		paddr <= ~a;
		pwdata <= ~d;
		if (n >= 64)
			test_saceng_top.end_of_test(1'b1);
	endtask : xfer
	// read one register
	task automatic rd(input logic [11:0] a, output logic [31:0] r, output logic e);
		xfer(1'b0, a, 32'h0, r, e);
	endtask : rd
	// ************************************
	// command lists
	// ************************************
	// code first, then parameters
	task automatic cmd(input logic [31:0] q [$]);
		logic [31:0] r;
		logic        e;
		foreach (q[i])
			xfer(1'b1, OFS_PARAM, q[i], r, e);
		xfer(1'b1, OFS_EXEC, 32'h0, r, e);
	endtask : cmd
	// poll until acquisition reaches a state
	task automatic wait_state(input logic [1:0] s);
		logic [31:0] r;
		logic        e;
		int          n;
		n = 0;
		do begin
			rd(OFS_STATUS, r, e);
			n++;
		end while (r[1:0] !== s && n < 300);
		if (n >= 300)
			test_saceng_top.end_of_test(1'b1);
	endtask : wait_state
endmodule : saceng_host

// ---- testbench/test_saceng_top.sv ----
// self-checking testbench of the sensor acquisition command engine
`timescale 1ns/100ps
module test_saceng_top
	import saceng_pkg::*;
;
	// ************************************
	// signals and instances
	// ************************************
	localparam logic [31:0] IVL   = 32'h0000_0014;
	localparam int          IVL_T = 3;
	logic           mclk;
	logic           nrst;
	logic           psel;
	logic           penable;
	logic           pwrite;
	logic    [11:0] paddr;
	logic    [31:0] pwdata;
	logic    [31:0] prdata;
	logic           pready;
	logic           pslverr;
	saceng_sense_t  sense;
	logic           start_btn;
	logic           acq_busy;
	int             err_count;
	int             checked;
	logic    [31:0] r;
	logic           e;
	// engine with a short time base tick
	saceng_top #(.TICK_CYCLES(4)) i_saceng_top (
		.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sense(sense),
		.start_btn(start_btn), .acq_busy(acq_busy)
	);
	// host side of the link
	saceng_host i_saceng_host (
		.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr)
	);
	// 200 mhz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// ************************************
	// helpers
	// ************************************
	// integer in the 16 fraction bit number format
	function automatic logic [31:0] q(input int n);
		return 32'(n) << 16;
	endfunction : q
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// read a register and compare
	task automatic see(input logic [11:0] a, input logic [31:0] x);
		i_saceng_host.rd(a, r, e);
		chk(r, x);
	endtask : see
	// clear everything and set up channel 1 with a self-calibrating probe
	task automatic base;
		i_saceng_host.cmd('{q(0)});
		i_saceng_host.cmd('{q(1), q(1), q(1)});
	endtask : base
	// bounded wait for a fresh reading
	task automatic wait_fresh;
		int n;
		n = 0;
		do begin
			i_saceng_host.rd(OFS_STATUS, r, e);
			n++;
		end while (r[ST_FRESH_BIT] !== 1'b1 && n < 100);
		if (n >= 100)
			end_of_test(1'b1);
	endtask : wait_fresh
	// refused command leaves only the parameter error
	task automatic bad(input logic [31:0] l [$]);
		base();
		i_saceng_host.cmd(l);
		see(OFS_STATUS, 32'h1 << ST_EPAR_BIT);
	endtask : bad
	// verdict
	task automatic end_of_test(input bit hang);
		if (hang)
			err_count++;
		$display("checks %0d, errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	// ************************************
	// scenarios
	// ************************************
	initial begin
		nrst = 1'b0;
		sense = '0;
		start_btn = 1'b0;
		err_count = 0;
		checked = 0;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		sense.analog[0] <= 32'h0002_0000;
		sense.analog[1] <= 32'h0002_0000;
		sense.analog[2] <= q(3);
		sense.analog[3] <= -q(1);
		sense.motion[0] <= 32'h0001_2345;
		sense.motion[1] <= 32'h0003_0001;
		@(posedge mclk);
		chk({31'h0, acq_busy}, 32'h0);
		see(OFS_STATUS, 32'h0);
		i_saceng_host.rd(12'h010, r, e);
		chk({r[30:0], e}, 32'h1);
		// single reads: auto probe, linear calibration, motion channels
		base();
		i_saceng_host.cmd('{q(9), q(1)});
		see(OFS_DATA, 32'h0002_0000);
		i_saceng_host.cmd('{q(1), q(2), q(0), q(0), q(0), q(1)});
		i_saceng_host.cmd('{q(4), q(2), q(1), 32'h0000_8000, 32'h0003_0000});
		i_saceng_host.cmd('{q(9), q(2)});
		see(OFS_DATA, 32'h0006_8000);
		i_saceng_host.cmd('{q(1), q(4), q(0), q(0), q(0), q(1)});
		i_saceng_host.cmd('{q(4), q(4), q(1), q(1), q(2)});
		i_saceng_host.cmd('{q(9), q(4)});
		see(OFS_DATA, 32'hFFFF_0000);
		for (int i = 0; i < 2; i++) begin
			// each channel set up before its read
			i_saceng_host.cmd('{q(1), q(11 + i), q(1)});
			i_saceng_host.cmd('{q(9), q(11 + i)});
			see(OFS_DATA, sense.motion[i]);
		end
		see(OFS_STATUS, 32'h0);
		i_saceng_host.cmd('{q(9), q(3)});
		see(OFS_STATUS, 32'h1 << ST_ECH_BIT);
		see(OFS_DATA, 32'h0);
		i_saceng_host.cmd('{q(0)});
		i_saceng_host.cmd('{q(3), IVL, q(1), q(0)});
		see(OFS_STATUS, 32'h1 << ST_ECH_BIT);
		// refused intervals, counts and codes
		bad('{q(3), 32'h0, q(1), q(0)});
		bad('{q(3), IVL_MAX_Q + 32'h1, q(1), q(0)});
		bad('{q(3), 32'h5, q(1), q(0)});
		bad('{q(3), IVL, q(12288), q(0)});
		bad('{q(3), IVL, q(0), q(0)});
		bad('{q(2)});
		// largest interval and count accepted, then stopped
		base();
		i_saceng_host.cmd('{q(3), IVL_MAX_Q, q(12287), q(0)});
		see(OFS_STATUS, 32'h3);
		chk({31'h0, acq_busy}, 32'h1);
		i_saceng_host.cmd('{q(6), q(0)});
		see(OFS_STATUS, 32'h0);
		// stored run of three readings
		i_saceng_host.cmd('{q(3), IVL, q(3), q(0)});
		i_saceng_host.wait_state(2'b10);
		see(OFS_STATUS, 32'h2 | (32'h3 << ST_NDONE_LSB));
		for (int k = 0; k < 3; k++)
			see(OFS_DATA, 32'h0002_0000);
		for (int k = 0; k < 3; k++)
			see(OFS_DATA, 32'((k + 1) * IVL_T));
		// live sampling follows the sensor until stopped
		base();
		i_saceng_host.cmd('{q(3), IVL, q(-1), q(0)});
		wait_fresh();
		see(OFS_DATA, 32'h0002_0000);
		sense.analog[0] <= 32'h0005_0000;
		wait_fresh();
		see(OFS_DATA, 32'h0005_0000);
		wait_fresh();
		see(OFS_DATA, 32'h0005_0000);
		i_saceng_host.rd(OFS_STATUS, r, e);
		chk(r & 32'h7, 32'h7);
		i_saceng_host.cmd('{q(6), q(0)});
		see(OFS_STATUS, 32'h0);
		chk({31'h0, acq_busy}, 32'h0);
		// omitted trigger waits for the button
		i_saceng_host.cmd('{q(3), IVL});
		repeat (40) @(posedge mclk);
		see(OFS_STATUS, 32'h1);
		start_btn <= 1'b1;
		repeat (4) @(posedge mclk);
		start_btn <= 1'b0;
		i_saceng_host.wait_state(2'b10);
		see(OFS_STATUS, 32'h2 | (32'h1 << ST_NDONE_LSB));
		// level trigger fires only above the threshold
		i_saceng_host.cmd('{q(3), IVL, q(1), q(2), q(1), 32'h0006_0000});
		sense.analog[0] <= 32'h0006_0000;
		repeat (40) @(posedge mclk);
		see(OFS_STATUS, 32'h1);
		sense.analog[0] <= 32'h0006_0001;
		i_saceng_host.wait_state(2'b10);
		see(OFS_DATA, 32'h0006_0001);
		// hardware reset in the middle of a live run
		i_saceng_host.cmd('{q(3), IVL, q(-1), q(0)});
		@(posedge mclk);
		chk({31'h0, acq_busy}, 32'h1);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({31'h0, acq_busy}, 32'h0);
		nrst <= 1'b1;
		@(posedge mclk);
		see(OFS_STATUS, 32'h0);
		end_of_test(1'b0);
	end
endmodule : test_saceng_top
